// file: design/bit_exec_pkg.sv
// Shared constants and types for the bit, table and move execution unit
`default_nettype none
package bit_exec_pkg;
	localparam int RAM_DEPTH = 1024;
	localparam logic [15:0] RAM_LIMIT = 16'h0400;
	localparam logic [7:0] WIDE_OOB_READ = 8'h00;
	localparam logic [3:0] BIT_RAM_BASE = 4'h2;
	localparam logic [7:0] STATUS_BYTE = 8'hd0;
	localparam logic [7:0] ACC_BYTE = 8'he0;
	localparam logic [1:0] PORT_GROUP = 2'b10;
	localparam logic [3:0] PORT_LOW = 4'h0;
	localparam int STATUS_CARRY = 7;
	localparam int STATUS_BANK_HI = 4;
	localparam int STATUS_BANK_LO = 3;
	localparam logic [7:0] ACC_RESET = 8'h00;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [15:0] WIDE_RESET = 16'h0000;
	localparam logic [15:0] PC_RESET = 16'h0000;
	localparam logic [7:0] PORT_RESET = 8'hff;
	localparam int NUM_PORTS = 4;

	typedef enum logic [4:0] {
		OP_NOP = 5'h00,
		OP_LOAD_ACC = 5'h01,
		OP_LOAD_WIDE = 5'h02,
		OP_LOAD_RAM = 5'h03,
		OP_PTR_READ = 5'h04,
		OP_PTR_WRITE = 5'h05,
		OP_WIDE_READ = 5'h06,
		OP_WIDE_WRITE = 5'h07,
		OP_CONST_WIDE = 5'h08,
		OP_CONST_PC = 5'h09,
		OP_MOV_C_BIT = 5'h0a,
		OP_MOV_BIT_C = 5'h0b,
		OP_CLR_C = 5'h0c,
		OP_CLR_BIT = 5'h0d,
		OP_SET_C = 5'h0e,
		OP_SET_BIT = 5'h0f,
		OP_INV_C = 5'h10,
		OP_INV_BIT = 5'h11,
		OP_AND_C_BIT = 5'h12,
		OP_AND_C_NBIT = 5'h13,
		OP_OR_C_BIT = 5'h14,
		OP_OR_C_NBIT = 5'h15,
		OP_BR_CARRY_HIGH = 5'h16,
		OP_BR_CARRY_LOW = 5'h17,
		OP_BR_BIT_HIGH = 5'h18,
		OP_BR_BIT_LOW = 5'h19,
		OP_BR_TEST_CLEAR = 5'h1a
	} op_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ISSUE = 2'b01,
		ST_CAPTURE = 2'b10
	} state_t;
endpackage : bit_exec_pkg
`default_nettype wire

// file: design/bit_addr_decode.sv
// Splits a direct bit address into byte location and bit index
`default_nettype none
module bit_addr_decode import bit_exec_pkg::*; (
	input wire logic [7:0] bit_addr,
	output logic in_ram,
	output logic [7:0] byte_addr,
	output logic [2:0] bit_idx
);
	// Low half is the RAM bit page, high half is special register space
	assign in_ram = ~bit_addr[7];
	assign byte_addr = in_ram ? {BIT_RAM_BASE, bit_addr[6:3]} : {bit_addr[7:3], 3'b000};
	assign bit_idx = bit_addr[2:0];
endmodule : bit_addr_decode
`default_nettype wire

// file: design/rel_target_calc.sv
// Signed relative branch target from the following instruction address
`default_nettype none
module rel_target_calc (
	input wire logic [15:0] pc_next,
	input wire logic [7:0] rel,
	output logic [15:0] target
);
	assign target = pc_next + {{8{rel[7]}}, rel};
endmodule : rel_target_calc
`default_nettype wire

// file: design/bit_table_move_execution.sv
// Execution unit for internal RAM moves, table reads, bit ops and bit branches
// Functional notes
// - Internal RAM move group never reaches external memory, only internal RAM.
// - Moves use indirect pointer or wide pointer, each with read and write.
// - Byte pointer comes from pointer register zero or one of current bank.
// - Table read fetches program byte at accumulator plus wide pointer.
// - Table read fetches program byte at accumulator plus next instruction address.
// - Program memory is only read, never written.
// - 128 RAM bits in one page plus up to 128 special register bits.
// - Bit addresses below 80h hit RAM page, the rest hit special registers.
// - Each port line is written alone, other lines unchanged.
// - Moving a bit to a port line sets or clears it to match.
// - Carry is the Boolean accumulator and has its own bit address.
// - Move bit to carry, carry to bit, clear, set, complement supported.
// - Carry AND, AND NOT, OR, OR NOT with a bit; no XOR.
// - Branch on carry high, carry low, bit high or bit low.
// - Test-and-clear branch jumps on bit high and clears that bit.
// - All status word bits are bit-addressable and testable.
// - Taken branch adds signed offset byte to program counter.
// - Branch reach is -128 to +127 from the following instruction.
`default_nettype none
module bit_table_move_execution import bit_exec_pkg::*; (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic cmd_valid,
	input wire op_t cmd_op,
	input wire logic [7:0] cmd_data,
	input wire logic [15:0] cmd_wide,
	input wire logic cmd_ptr_sel,
	input wire logic [7:0] cmd_bit_addr,
	input wire logic [7:0] cmd_rel,
	input wire logic [15:0] cmd_pc_next,
	input wire logic [7:0] prog_data,
	output logic busy,
	output logic done,
	output logic branch_taken,
	output logic [15:0] pc,
	output logic [7:0] acc,
	output logic [7:0] status_word,
	output logic [15:0] wide_ptr,
	output logic [NUM_PORTS-1:0][7:0] port_out,
	output logic prog_rd,
	output logic [15:0] prog_addr
);
	logic [7:0] ram [RAM_DEPTH];
	state_t state;

	wire take = cmd_valid && !busy;
	wire carry = status_word[STATUS_CARRY];

	// Bit address decode
	logic in_ram;
	logic [7:0] byte_addr;
	logic [2:0] bit_idx;
	bit_addr_decode u_decode (
		.bit_addr(cmd_bit_addr),
		.in_ram(in_ram),
		.byte_addr(byte_addr),
		.bit_idx(bit_idx)
	);

	logic [15:0] rel_target;
	rel_target_calc u_rel (
		.pc_next(cmd_pc_next),
		.rel(cmd_rel),
		.target(rel_target)
	);

	// Special register byte read for bit-addressable registers
	wire is_port = !in_ram && byte_addr[7:6] == PORT_GROUP
		&& byte_addr[3:0] == PORT_LOW;
	wire [1:0] port_idx = byte_addr[5:4];
	wire is_status = !in_ram && byte_addr == STATUS_BYTE;
	wire is_acc = !in_ram && byte_addr == ACC_BYTE;
	wire [7:0] special_byte = is_port ? port_out[port_idx]
		: is_status ? status_word
		: is_acc ? acc : 8'h00;
	wire [7:0] bit_byte = in_ram ? ram[{2'b00, byte_addr}] : special_byte;
	wire bit_val = bit_byte[bit_idx];

	// Boolean processor
	wire op_bit_wr = cmd_op == OP_MOV_BIT_C || cmd_op == OP_CLR_BIT || cmd_op == OP_SET_BIT
		|| cmd_op == OP_INV_BIT || (cmd_op == OP_BR_TEST_CLEAR && bit_val);
	wire bit_wr_en = take && op_bit_wr;
	wire bit_new = cmd_op == OP_MOV_BIT_C ? carry : cmd_op == OP_SET_BIT ? 1'b1
		: cmd_op == OP_INV_BIT ? ~bit_val : 1'b0;
	wire [7:0] bit_mask = 8'h01 << bit_idx;
	wire [7:0] bit_wr_byte = (bit_byte & ~bit_mask) | ({7'h00, bit_new} << bit_idx);

	logic carry_wr_en;
	logic carry_new;
	always_comb begin
		carry_wr_en = take;
		carry_new = carry;
		unique case (cmd_op)
			OP_MOV_C_BIT: carry_new = bit_val;
			OP_CLR_C: carry_new = 1'b0;
			OP_SET_C: carry_new = 1'b1;
			OP_INV_C: carry_new = ~carry;
			OP_AND_C_BIT: carry_new = carry & bit_val;
			OP_AND_C_NBIT: carry_new = carry & ~bit_val;
			OP_OR_C_BIT: carry_new = carry | bit_val;
			OP_OR_C_NBIT: carry_new = carry | ~bit_val;
			default: carry_wr_en = 1'b0;
		endcase
	end

	// Branch conditions
	wire jump = (cmd_op == OP_BR_CARRY_HIGH && carry)
		|| (cmd_op == OP_BR_CARRY_LOW && !carry)
		|| (cmd_op == OP_BR_BIT_HIGH && bit_val)
		|| (cmd_op == OP_BR_BIT_LOW && !bit_val)
		|| (cmd_op == OP_BR_TEST_CLEAR && bit_val);

	// Internal RAM moves
	wire [9:0] ptr_reg_addr = {5'h00, status_word[STATUS_BANK_HI:STATUS_BANK_LO], 2'b00,
		cmd_ptr_sel};
	wire [9:0] ptr_addr = {2'b00, ram[ptr_reg_addr]};
	wire wide_in = wide_ptr < RAM_LIMIT;
	wire [7:0] wide_rd = wide_in ? ram[wide_ptr[9:0]] : WIDE_OOB_READ;

	wire ram_we = take && ((cmd_op == OP_LOAD_RAM) || (cmd_op == OP_PTR_WRITE)
		|| (cmd_op == OP_WIDE_WRITE && wide_in) || (op_bit_wr && in_ram));
	wire [9:0] ram_waddr = cmd_op == OP_LOAD_RAM ? cmd_wide[9:0] : cmd_op == OP_PTR_WRITE
		? ptr_addr : cmd_op == OP_WIDE_WRITE ? wide_ptr[9:0] : {2'b00, byte_addr};
	wire [7:0] ram_wdata = cmd_op == OP_LOAD_RAM ? cmd_data
		: (cmd_op == OP_PTR_WRITE || cmd_op == OP_WIDE_WRITE) ? acc : bit_wr_byte;

	// Program memory table addresses; read-only port
	wire is_const = cmd_op == OP_CONST_WIDE || cmd_op == OP_CONST_PC;
	wire [15:0] const_addr = cmd_op == OP_CONST_WIDE ? wide_ptr + {8'h00, acc}
		: cmd_pc_next + {8'h00, acc};

	// Next values
	wire [7:0] next_acc = state == ST_CAPTURE ? prog_data
		: !take ? acc
		: cmd_op == OP_LOAD_ACC ? cmd_data
		: cmd_op == OP_PTR_READ ? ram[ptr_addr]
		: cmd_op == OP_WIDE_READ ? wide_rd
		: (bit_wr_en && is_acc) ? bit_wr_byte : acc;
	wire [7:0] next_status = (bit_wr_en && is_status) ? bit_wr_byte
		: carry_wr_en ? {carry_new, status_word[6:0]} : status_word;
	wire [15:0] next_wide = (take && cmd_op == OP_LOAD_WIDE) ? cmd_wide : wide_ptr;

	always_ff @(posedge clk_sys) begin
		if (ram_we) begin
			ram[ram_waddr] <= ram_wdata;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			acc <= ACC_RESET;
			status_word <= STATUS_RESET;
			wide_ptr <= WIDE_RESET;
		end else begin
			acc <= next_acc;
			status_word <= next_status;
			wide_ptr <= next_wide;
		end
	end

	// Port latches, one bit written at a time
	genvar gp;
	generate
		for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
			wire hit = bit_wr_en && is_port && port_idx == 2'(gp);
			always_ff @(posedge clk_sys) begin
				if (srst) begin
					port_out[gp] <= PORT_RESET;
				end else if (hit) begin
					port_out[gp] <= bit_wr_byte;
				end
			end
		end
	endgenerate

	// Sequencer and program counter
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			state <= ST_IDLE;
			busy <= 1'b0;
			done <= 1'b0;
			branch_taken <= 1'b0;
			pc <= PC_RESET;
			prog_rd <= 1'b0;
			prog_addr <= PC_RESET;
		end else begin
			done <= 1'b0;
			branch_taken <= 1'b0;
			prog_rd <= 1'b0;
			unique case (state)
				ST_IDLE: begin
					if (take) begin
						pc <= jump ? rel_target : cmd_pc_next;
						branch_taken <= jump;
						if (is_const) begin
							state <= ST_ISSUE;
							busy <= 1'b1;
							prog_rd <= 1'b1;
							prog_addr <= const_addr;
						end else begin
							done <= 1'b1;
						end
					end
				end
				ST_ISSUE: begin
					state <= ST_CAPTURE;
				end
				ST_CAPTURE: begin
					state <= ST_IDLE;
					busy <= 1'b0;
					done <= 1'b1;
				end
				default: begin
					state <= ST_IDLE;
					busy <= 1'b0;
				end
			endcase
		end
	end

	// Checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);

	a_wide_table_addr: assert property (take && cmd_op == OP_CONST_WIDE |=>
		prog_rd && prog_addr == $past(wide_ptr) + {8'h00, $past(acc)})
		else $error("table read address is not acc plus wide pointer");
	a_pc_table_load: assert property (take && cmd_op == OP_CONST_PC |=>
		prog_addr == $past(cmd_pc_next) + {8'h00, $past(acc)} ##2 done && acc == $past(prog_data))
		else $error("pc table read did not load accumulator");
	a_prog_rd_bounded: assert property (prog_rd |-> busy ##1 !prog_rd)
		else $error("program memory read outside a table fetch");
	a_wide_oob_read: assert property (take && cmd_op == OP_WIDE_READ && !wide_in |=>
		acc == WIDE_OOB_READ)
		else $error("out of range wide pointer read not fixed");
	a_ptr_write_ram: assert property (take && cmd_op == OP_PTR_WRITE |=>
		ram[$past(ptr_addr)] == $past(acc))
		else $error("pointer write did not reach internal RAM");
	a_port_line_set: assert property (take && cmd_op == OP_MOV_BIT_C && is_port |=>
		port_out[$past(port_idx)][$past(bit_idx)] == $past(carry))
		else $error("port line does not follow carry");
	a_port_others_kept: assert property (take && op_bit_wr && is_port |=>
		(port_out[$past(port_idx)] & ~$past(bit_mask)) == ($past(bit_byte) & ~$past(bit_mask)))
		else $error("other port lines disturbed");
	a_and_not_carry: assert property (take && cmd_op == OP_AND_C_NBIT |=>
		status_word[STATUS_CARRY] == ($past(carry) & ~$past(bit_val)))
		else $error("carry and-not result wrong");
	a_or_not_carry: assert property (take && cmd_op == OP_OR_C_NBIT |=>
		status_word[STATUS_CARRY] == ($past(carry) | ~$past(bit_val)))
		else $error("carry or-not result wrong");
	a_clr_carry: assert property (take && cmd_op == OP_CLR_C |=>
		!status_word[STATUS_CARRY])
		else $error("carry not cleared");
	a_carry_bit_addr: assert property (take && cmd_op == OP_SET_BIT && is_status
		&& bit_idx == 3'd7 |=> status_word[STATUS_CARRY] && done)
		else $error("carry not reached through its bit address");
	a_test_clear: assert property (take && cmd_op == OP_BR_TEST_CLEAR && bit_val && in_ram |=>
		branch_taken && !ram[$past({2'b00, byte_addr})][$past(bit_idx)])
		else $error("test and clear branch did not clear bit");
	a_carry_low_fall: assert property (take && cmd_op == OP_BR_CARRY_LOW && carry |=>
		!branch_taken && pc == $past(cmd_pc_next))
		else $error("carry low branch taken with carry set");
	a_bit_high_fall: assert property (take && cmd_op == OP_BR_BIT_HIGH && !bit_val |=>
		!branch_taken && pc == $past(cmd_pc_next))
		else $error("bit high branch taken with bit clear");
	a_status_bit_test: assert property (take && cmd_op == OP_BR_BIT_HIGH && is_status |=>
		branch_taken == $past(status_word[bit_idx]))
		else $error("status bit test wrong");
	a_rel_back_max: assert property (take && jump && cmd_rel == 8'h80 |=>
		pc == $past(cmd_pc_next) - 16'h0080)
		else $error("most negative offset target wrong");
	a_rel_fwd_max: assert property (take && jump && cmd_rel == 8'h7f |=>
		pc == $past(cmd_pc_next) + 16'h007f)
		else $error("most positive offset target wrong");
	a_taken_flag: assert property (take && jump |=> branch_taken && done)
		else $error("taken branch not flagged");
	a_bank_ptr_read: assert property (take && cmd_op == OP_PTR_READ |=>
		acc == $past(ram[{2'b00, ram[ptr_reg_addr]}]) && done)
		else $error("pointer read did not load accumulator");
	a_wide_write_ram: assert property (take && cmd_op == OP_WIDE_WRITE && wide_in |=>
		ram[$past(wide_ptr[9:0])] == $past(acc))
		else $error("wide pointer write did not reach internal RAM");
	a_bit_ram_page: assert property (take && cmd_op == OP_SET_BIT && in_ram |=>
		ram[$past({6'h02, cmd_bit_addr[6:3]})][$past(cmd_bit_addr[2:0])])
		else $error("RAM page bit not set");
	a_port_line_clear: assert property (take && cmd_op == OP_CLR_BIT && is_port |=>
		!port_out[$past(port_idx)][$past(bit_idx)])
		else $error("port line not cleared");
	a_table_busy: assert property (take && is_const |=>
		busy ##1 busy ##1 !busy && done)
		else $error("table fetch sequence wrong");

	c_pc_table: cover property (take && cmd_op == OP_CONST_PC ##3 done);
	c_test_clear_taken: cover property (take && cmd_op == OP_BR_TEST_CLEAR && bit_val);
	c_port_write: cover property (take && cmd_op == OP_MOV_BIT_C && is_port);
	c_wide_read: cover property (take && cmd_op == OP_WIDE_READ && wide_in);
	c_wide_oob: cover property (take && cmd_op == OP_WIDE_READ && !wide_in);
endmodule : bit_table_move_execution
`default_nettype wire

// file: verif/prog_mem_model.sv
// Registered program memory model answering table reads
`default_nettype none
module prog_mem_model (
	input wire logic clk_sys,
	input wire logic prog_rd,
	input wire logic [15:0] prog_addr,
	output logic [7:0] prog_data
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] q = 8'h00;
	logic live = 1'b0;
	// Read path only, no write port
	always @(posedge clk_sys) begin
		live <= prog_rd;
		if (prog_rd) begin
			q <= prog_addr[7:0] ^ prog_addr[15:8] ^ 8'h3c;
		end
	end
	// Released bus shows the inverse of the last byte
	assign prog_data = live ? q : ~q;
endmodule : prog_mem_model
`default_nettype wire

// file: verif/bit_table_move_execution_tb.sv
// Self-checking bench for the bit, table and move execution unit
`default_nettype none
module bit_table_move_execution_tb import bit_exec_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	logic cmd_valid = 1'b0;
	logic cmd_ptr_sel = 1'b0;
	op_t cmd_op = OP_NOP;
	logic [7:0] cmd_data = 8'h00;
	logic [7:0] cmd_bit_addr = 8'h00;
	logic [7:0] cmd_rel = 8'h00;
	logic [15:0] cmd_wide = 16'h0000;
	logic [15:0] cmd_pc_next = 16'h1000;
	logic [7:0] prog_data, acc, status_word;
	logic busy, done, branch_taken, prog_rd, took;
	logic [15:0] pc, wide_ptr, prog_addr;
	logic [NUM_PORTS-1:0][7:0] port_out;
	int num_errors = 0;
	int total_checks = 0;

	bit_table_move_execution dut (.clk_sys(clk_sys), .srst(srst), .cmd_valid(cmd_valid),
		.cmd_op(cmd_op), .cmd_data(cmd_data), .cmd_wide(cmd_wide), .cmd_ptr_sel(cmd_ptr_sel),
		.cmd_bit_addr(cmd_bit_addr), .cmd_rel(cmd_rel), .cmd_pc_next(cmd_pc_next),
		.prog_data(prog_data), .busy(busy), .done(done), .branch_taken(branch_taken), .pc(pc),
		.acc(acc), .status_word(status_word), .wide_ptr(wide_ptr), .port_out(port_out),
		.prog_rd(prog_rd),
		.prog_addr(prog_addr));
	prog_mem_model mem (.clk_sys(clk_sys), .prog_rd(prog_rd), .prog_addr(prog_addr),
		.prog_data(prog_data));

	initial begin
		forever #2 clk_sys = ~clk_sys;
	end

	task automatic final_report();
		$display("checks=%0d errors=%0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : final_report

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// One command, waits for done
	task automatic run(input op_t op, input logic [7:0] d, input logic [15:0] w,
			input logic s, input logic [7:0] b, input logic [7:0] r);
		int n;
		n = 0;
		@(posedge clk_sys);
		cmd_valid <= 1'b1;
		cmd_op <= op;
		cmd_data <= d;
		cmd_wide <= w;
		cmd_ptr_sel <= s;
		cmd_bit_addr <= b;
		cmd_rel <= r;
		@(posedge clk_sys);
		cmd_valid <= 1'b0;
		#1;
		while (done !== 1'b1 && n < 8) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		check(16'(done), 16'h0001);
		check(16'({busy, prog_rd}), 16'h0000);
		took = branch_taken;
	endtask : run

	task automatic bop(input op_t op, input logic [7:0] b);
		run(op, 8'h00, 16'h0000, 1'b0, b, 8'h00);
	endtask : bop

	task automatic bitc(input op_t op, input logic [7:0] b, input logic exp);
		bop(op, b);
		check(16'(status_word[7]), 16'(exp));
	endtask : bitc

	task automatic brn(input op_t op, input logic [7:0] b, input logic [7:0] r,
			input logic exp, input logic [15:0] target);
		run(op, 8'h00, 16'h0000, 1'b0, b, r);
		check(16'(took), 16'(exp));
		check(pc, target);
	endtask : brn

	task automatic t_moves();
		bop(OP_SET_BIT, 8'hd3);
		check(16'(status_word[4:3]), 16'h0001);
		run(OP_LOAD_RAM, 8'h40, 16'h0009, 1'b0, 8'h00, 8'h00);
		run(OP_LOAD_RAM, 8'h50, 16'h0008, 1'b0, 8'h00, 8'h00);
		run(OP_LOAD_ACC, 8'ha5, 16'h0000, 1'b0, 8'h00, 8'h00);
		run(OP_PTR_WRITE, 8'h00, 16'h0000, 1'b1, 8'h00, 8'h00);
		run(OP_LOAD_ACC, 8'h3c, 16'h0000, 1'b0, 8'h00, 8'h00);
		run(OP_PTR_WRITE, 8'h00, 16'h0000, 1'b0, 8'h00, 8'h00);
		run(OP_LOAD_WIDE, 8'h00, 16'h0040, 1'b0, 8'h00, 8'h00);
		check(wide_ptr, 16'h0040);
		run(OP_WIDE_READ, 8'h00, 16'h0000, 1'b0, 8'h00, 8'h00);
		check(16'(acc), 16'h00a5);
		run(OP_PTR_READ, 8'h00, 16'h0000, 1'b0, 8'h00, 8'h00);
		check(16'(acc), 16'h003c);
		run(OP_LOAD_WIDE, 8'h00, 16'h0440, 1'b0, 8'h00, 8'h00);
		check(wide_ptr, 16'h0440);
		run(OP_WIDE_WRITE, 8'h00, 16'h0000, 1'b0, 8'h00, 8'h00);
		run(OP_WIDE_READ, 8'h00, 16'h0000, 1'b0, 8'h00, 8'h00);
		check(16'(acc), 16'h0000);
		run(OP_LOAD_WIDE, 8'h00, 16'h0040, 1'b0, 8'h00, 8'h00);
		run(OP_WIDE_READ, 8'h00, 16'h0000, 1'b0, 8'h00, 8'h00);
		check(16'(acc), 16'h00a5);
		bop(OP_CLR_BIT, 8'hd3);
	endtask : t_moves

	task automatic t_tables();
		run(OP_LOAD_ACC, 8'h10, 16'h0000, 1'b0, 8'h00, 8'h00);
		run(OP_LOAD_WIDE, 8'h00, 16'h12f8, 1'b0, 8'h00, 8'h00);
		run(OP_CONST_WIDE, 8'h00, 16'h0000, 1'b0, 8'h00, 8'h00);
		check(prog_addr, 16'h1308);
		check(16'(acc), 16'(8'h08 ^ 8'h13 ^ 8'h3c));
		run(OP_LOAD_ACC, 8'h02, 16'h0000, 1'b0, 8'h00, 8'h00);
		run(OP_LOAD_WIDE, 8'h00, 16'hffff, 1'b0, 8'h00, 8'h00);
		run(OP_CONST_WIDE, 8'h00, 16'h0000, 1'b0, 8'h00, 8'h00);
		check(prog_addr, 16'h0001);
		run(OP_LOAD_ACC, 8'hff, 16'h0000, 1'b0, 8'h00, 8'h00);
		run(OP_CONST_PC, 8'h00, 16'h0000, 1'b0, 8'h00, 8'h00);
		check(prog_addr, 16'h10ff);
		check(16'(acc), 16'(8'hff ^ 8'h10 ^ 8'h3c));
		check(pc, 16'h1000);
	endtask : t_tables

	task automatic t_bits();
		bop(OP_SET_BIT, 8'h05);
		bop(OP_CLR_BIT, 8'h06);
		bitc(OP_CLR_C, 8'h00, 1'b0);
		bitc(OP_SET_C, 8'h00, 1'b1);
		bitc(OP_INV_C, 8'h00, 1'b0);
		bitc(OP_MOV_C_BIT, 8'h05, 1'b1);
		bitc(OP_AND_C_BIT, 8'h06, 1'b0);
		bitc(OP_OR_C_BIT, 8'h05, 1'b1);
		bitc(OP_AND_C_NBIT, 8'h05, 1'b0);
		bitc(OP_OR_C_NBIT, 8'h06, 1'b1);
		bitc(OP_INV_BIT, 8'h06, 1'b1);
		bitc(OP_CLR_C, 8'h00, 1'b0);
		bitc(OP_MOV_C_BIT, 8'h06, 1'b1);
		bitc(OP_MOV_BIT_C, 8'h7f, 1'b1);
		bitc(OP_CLR_C, 8'h00, 1'b0);
		bitc(OP_MOV_C_BIT, 8'h7f, 1'b1);
		check(16'(port_out[0]), 16'h00ff);
		bitc(OP_CLR_BIT, 8'hd7, 1'b0);
		bitc(OP_SET_BIT, 8'hd7, 1'b1);
	endtask : t_bits

	task automatic t_ports();
		bitc(OP_CLR_C, 8'h00, 1'b0);
		bop(OP_MOV_BIT_C, 8'h90);
		check(16'(port_out[1]), 16'h00fe);
		check(16'(port_out[0]), 16'h00ff);
		bitc(OP_SET_C, 8'h00, 1'b1);
		bop(OP_MOV_BIT_C, 8'h90);
		check(16'(port_out[1]), 16'h00ff);
		bop(OP_CLR_BIT, 8'hb7);
		check(16'(port_out[3]), 16'h007f);
		check(16'(port_out[2]), 16'h00ff);
	endtask : t_ports

	task automatic t_branches();
		brn(OP_BR_CARRY_HIGH, 8'h00, 8'h80, 1'b1, 16'h0f80);
		brn(OP_BR_CARRY_LOW, 8'h00, 8'h80, 1'b0, 16'h1000);
		bitc(OP_CLR_C, 8'h00, 1'b0);
		brn(OP_BR_CARRY_LOW, 8'h00, 8'h7f, 1'b1, 16'h107f);
		brn(OP_BR_CARRY_HIGH, 8'h00, 8'h7f, 1'b0, 16'h1000);
		brn(OP_BR_BIT_HIGH, 8'h05, 8'h7f, 1'b1, 16'h107f);
		brn(OP_BR_BIT_LOW, 8'h05, 8'h10, 1'b0, 16'h1000);
		brn(OP_BR_TEST_CLEAR, 8'h05, 8'hfe, 1'b1, 16'h0ffe);
		brn(OP_BR_BIT_HIGH, 8'h05, 8'h01, 1'b0, 16'h1000);
		brn(OP_BR_BIT_LOW, 8'h05, 8'h01, 1'b1, 16'h1001);
		brn(OP_BR_TEST_CLEAR, 8'h05, 8'h01, 1'b0, 16'h1000);
		bop(OP_SET_BIT, 8'hd1);
		brn(OP_BR_BIT_HIGH, 8'hd1, 8'h04, 1'b1, 16'h1004);
		brn(OP_BR_TEST_CLEAR, 8'hd1, 8'h04, 1'b1, 16'h1004);
		check(16'(status_word[1]), 16'h0000);
	endtask : t_branches

	initial begin
		#40000;
		num_errors++;
		final_report();
	end

	initial begin
		repeat (5) @(posedge clk_sys);
		srst <= 1'b0;
		t_moves();
		t_tables();
		t_bits();
		t_ports();
		t_branches();
		final_report();
	end
endmodule : bit_table_move_execution_tb
`default_nettype wire
